// ===== rtl/ocp_consts.svh
// Constants of the overcurrent protection block: timing counts and threshold codes.
// Assumes a 50 MHz mclk; included by the package and by the design.
`ifndef OCP_CONSTS_SVH
`define OCP_CONSTS_SVH
// Clock rate in Hz
`define OCP_CLK_HZ 50000000
// Fast delay unit, in ns (3.3 ms)
`define OCP_FAST_UNIT_NS 3300000
// Fast delay unit, in clock cycles
`define OCP_FAST_UNIT_CYC ((`OCP_FAST_UNIT_NS * 50) / 1000)
// Slow delay unit, in ms (1 s)
`define OCP_SLOW_UNIT_MS 1000
// Slow delay unit, in clock cycles
`define OCP_SLOW_UNIT_CYC ((`OCP_SLOW_UNIT_MS * 50000))
// Fixed extra units in the fast trip delay
`define OCP_FAST_BASE 2
// Threshold code meaning: mV = 4 + 2 * code
`define OCP_THR_MIN_MV 4
`define OCP_THR_STEP_MV 2
// Charge threshold code top (124 mV), discharge code top (200 mV)
`define OCP_CHG_THR_MAX 8'h3C
`define OCP_DSG_THR_MAX 8'h62
// Delay setting that switches charge protection off
`define OCP_CHG_DLY_OFF 7'h00
`endif

// ===== rtl/ocp_pkg.sv
// Types of the overcurrent protection block.
// Assumes ocp_consts.svh sits beside it.
`include "ocp_consts.svh"
package ocp_pkg;
   // Enable bits of the protections
   typedef struct packed {
      logic charge_switch;
      logic dsg1;
      logic dsg2;
      logic dsg3;
      logic latch;
   } prot_en_s;
   // Alert or status bits of the protections
   typedef struct packed {
      logic charge_switch;
      logic dsg1;
      logic dsg2;
      logic dsg3;
      logic latch;
   } prot_flags_s;
   // Latch protection state
   typedef enum logic [1:0] {LATCH_IDLE, LATCH_TRIPPED} latch_e;
endpackage

// ===== rtl/overcurrent_protection_fsm.sv
// Overcurrent protection for the charge and discharge paths of a battery monitor.
// Assumes comparator flags, current measurements and configuration arrive synchronous to mclk.
//
// Contract
// - Charge sense compared with 4-124 mV threshold
// - Charge protection runs only when enabled
// - Charge alert, fault after 3.3ms*(2+setting)
// - Charge delay setting zero disables protection
// - Charge fault: alert clears, status, charge-off alarm
// - Charge recovery by pack delta or current
// - Charge recovery clears status and alarm
// - Two discharge sense thresholds, 4-200 mV
// - Discharge levels 1,2 each own enable
// - Discharge levels 1,2 alert then delayed fault
// - Level 3 alerts on coulomb current below threshold
// - Level 3 fault after 0-255 s
// - Discharge faults drive discharge-off alarm if configured
// - Discharge faults recover on charging current
// - Each discharge fault increments latch counter
// - Latch counter decrements per quiet delay
// - Latch fault when counter exceeds limit
// - Latch alert while counter above zero; code drops it while the latch fault is set
// - Latch protection runs only when enabled
// - Latch recovery: load removal, current, time, command
// - Current recovery needs bit, series, charge on
`timescale 1ns/1ps
`include "ocp_consts.svh"
module overcurrent_protection_fsm
   import ocp_pkg::*;
#(
   parameter int CUR_W = 16,
   parameter int CNT_W = 8,
   parameter int FAST_UNIT = `OCP_FAST_UNIT_CYC,
   parameter int SLOW_UNIT = `OCP_SLOW_UNIT_CYC
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire prot_en_s prot_en,
   input wire logic [7:0] charge_sense_mv,
   input wire logic [7:0] discharge_sense_mv,
   input wire logic [5:0] charge_sense_threshold,
   input wire logic [6:0] discharge_sense_threshold_1,
   input wire logic [6:0] discharge_sense_threshold_2,
   input wire logic [6:0] charge_trip_delay,
   input wire logic [6:0] discharge_trip_delay_1,
   input wire logic [6:0] discharge_trip_delay_2,
   input wire logic [7:0] discharge_trip_delay_3,
   input wire logic signed [CUR_W-1:0] coulomb_counter_current,
   input wire logic signed [CUR_W-1:0] dsg3_threshold,
   input wire logic signed [CUR_W-1:0] chg_recovery_threshold,
   input wire logic signed [CUR_W-1:0] dsg_recovery_threshold,
   input wire logic signed [CUR_W-1:0] latch_recovery_threshold,
   input wire logic [7:0] recovery_time,
   input wire logic [7:0] latch_recovery_time,
   input wire logic [7:0] latch_reset_time,
   input wire logic [7:0] counter_dec_delay,
   input wire logic [CNT_W-1:0] latch_limit,
   input wire logic [CUR_W-1:0] pack_voltage,
   input wire logic [CUR_W-1:0] stack_voltage,
   input wire logic [CUR_W-1:0] pack_tos_delta,
   input wire logic chg_auto_en,
   input wire logic [2:0] dsg_auto_en,
   input wire logic latch_auto_en,
   input wire logic auto_recovery_en,
   input wire logic latch_current_recovery_en,
   input wire logic series_config,
   input wire logic charge_switch_on,
   input wire logic load_removed,
   input wire logic latch_recover_cmd,
   output prot_flags_s alert_q,
   output prot_flags_s status_q,
   output logic charge_off_alarm_q,
   output logic discharge_off_alarm_q,
   output logic [CNT_W-1:0] latch_count_q
);

   // ************************************************************
   // Helpers
   // ************************************************************

   // Threshold code to millivolts
   function automatic logic [8:0] code_mv(input logic [6:0] code);
      code_mv = 9'(`OCP_THR_MIN_MV) + 9'({code, 1'b0});
   endfunction

   // Fast trip delay in units of 3.3 ms
   function automatic logic [7:0] fast_units(input logic [6:0] dly);
      fast_units = 8'(dly) + 8'(`OCP_FAST_BASE);
   endfunction

   // ************************************************************
   // Timebases
   // ************************************************************

   logic [31:0] fast_div_q;
   logic [31:0] slow_div_q;
   logic fast_tick;
   logic slow_tick;
   assign fast_tick = (fast_div_q == 32'(FAST_UNIT - 1));
   assign slow_tick = (slow_div_q == 32'(SLOW_UNIT - 1));

   // Free-running dividers for the 3.3 ms and 1 s ticks
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fast_div_q <= 32'h0;
         slow_div_q <= 32'h0;
      end else begin
         fast_div_q <= fast_tick ? 32'h0 : fast_div_q + 32'h1;
         slow_div_q <= slow_tick ? 32'h0 : slow_div_q + 32'h1;
      end
   end

   // ************************************************************
   // Detection
   // ************************************************************

   logic chg_on;
   logic chg_det;
   logic dsg1_det;
   logic dsg2_det;
   logic dsg3_det;
   logic chg_rec_cond;
   logic dsg_rec_cond;
   logic latch_cur_cond;

   // Comparator decisions and recovery conditions
   assign chg_on = prot_en.charge_switch && (charge_trip_delay != `OCP_CHG_DLY_OFF);
   assign chg_det = chg_on && ({1'b0, charge_sense_mv} > code_mv({1'b0, charge_sense_threshold}));
   assign dsg1_det = prot_en.dsg1 && ({1'b0, discharge_sense_mv} > code_mv(discharge_sense_threshold_1));
   assign dsg2_det = prot_en.dsg2 && ({1'b0, discharge_sense_mv} > code_mv(discharge_sense_threshold_2));
   assign dsg3_det = prot_en.dsg3 && (coulomb_counter_current < dsg3_threshold);
   assign chg_rec_cond = (({1'b0, pack_voltage} + {1'b0, pack_tos_delta}) <= {1'b0, stack_voltage})
                         || (coulomb_counter_current <= chg_recovery_threshold);
   assign dsg_rec_cond = coulomb_counter_current >= dsg_recovery_threshold;
   assign latch_cur_cond = latch_current_recovery_en && series_config && charge_switch_on
                           && (coulomb_counter_current >= latch_recovery_threshold);

   // ************************************************************
   // Persistence timers
   // ************************************************************

   logic [7:0] chg_t_q, dsg1_t_q, dsg2_t_q, dsg3_t_q, chg_rt_q, dsg_rt_q, lat_rt_q;
   logic chg_trip, dsg1_trip, dsg2_trip, dsg3_trip, chg_rec, dsg_rec;
   logic [2:0] dsg_trip;
   logic dsg_any;
   assign chg_trip = chg_det && !status_q.charge_switch && fast_tick && (chg_t_q + 8'h1 >= fast_units(charge_trip_delay));
   assign dsg1_trip = dsg1_det && !status_q.dsg1 && fast_tick
                      && (dsg1_t_q + 8'h1 >= fast_units(discharge_trip_delay_1));
   assign dsg2_trip = dsg2_det && !status_q.dsg2 && fast_tick
                      && (dsg2_t_q + 8'h1 >= fast_units(discharge_trip_delay_2));
   assign dsg3_trip = dsg3_det && !status_q.dsg3 && (slow_tick || discharge_trip_delay_3 == 8'h0)
                      && (dsg3_t_q + 8'h1 >= discharge_trip_delay_3);
   assign chg_rec = status_q.charge_switch && auto_recovery_en && chg_rec_cond && slow_tick
                    && (chg_rt_q + 8'h1 >= recovery_time);
   assign dsg_any = status_q.dsg1 || status_q.dsg2 || status_q.dsg3;
   assign dsg_rec = dsg_any && dsg_rec_cond && slow_tick && (dsg_rt_q + 8'h1 >= recovery_time);
   assign dsg_trip = {dsg3_trip, dsg2_trip, dsg1_trip};

   // Count ticks while each condition holds; a break restarts the count
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         chg_t_q <= 8'h0;
         dsg1_t_q <= 8'h0;
         dsg2_t_q <= 8'h0;
         dsg3_t_q <= 8'h0;
      end else begin
         chg_t_q <= (!chg_det || status_q.charge_switch) ? 8'h0 : (fast_tick ? chg_t_q + 8'h1 : chg_t_q);
         dsg1_t_q <= (!dsg1_det || status_q.dsg1) ? 8'h0 : (fast_tick ? dsg1_t_q + 8'h1 : dsg1_t_q);
         dsg2_t_q <= (!dsg2_det || status_q.dsg2) ? 8'h0 : (fast_tick ? dsg2_t_q + 8'h1 : dsg2_t_q);
         dsg3_t_q <= (!dsg3_det || status_q.dsg3) ? 8'h0 : (slow_tick ? dsg3_t_q + 8'h1 : dsg3_t_q);
      end
   end

   // Recovery timers, in seconds
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         chg_rt_q <= 8'h0;
         dsg_rt_q <= 8'h0;
      end else begin
         chg_rt_q <= (!status_q.charge_switch || !chg_rec_cond) ? 8'h0 : (slow_tick ? chg_rt_q + 8'h1 : chg_rt_q);
         dsg_rt_q <= (!dsg_any || !dsg_rec_cond) ? 8'h0 : (slow_tick ? dsg_rt_q + 8'h1 : dsg_rt_q);
      end
   end

   // ************************************************************
   // Alerts and faults of the single levels
   // ************************************************************

   // Alerts follow detection and drop when the fault is raised
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         alert_q.charge_switch <= 1'b0;
         alert_q.dsg1 <= 1'b0;
         alert_q.dsg2 <= 1'b0;
         alert_q.dsg3 <= 1'b0;
      end else begin
         alert_q.charge_switch <= chg_det && !chg_trip && !status_q.charge_switch;
         alert_q.dsg1 <= dsg1_det && !dsg1_trip && !status_q.dsg1;
         alert_q.dsg2 <= dsg2_det && !dsg2_trip && !status_q.dsg2;
         alert_q.dsg3 <= dsg3_det && !dsg3_trip && !status_q.dsg3;
      end
   end

   // Fault status bits: trip sets, recovery or disable clears
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         status_q.charge_switch <= 1'b0;
         status_q.dsg1 <= 1'b0;
         status_q.dsg2 <= 1'b0;
         status_q.dsg3 <= 1'b0;
      end else begin
         status_q.charge_switch <= chg_on && (chg_trip || (status_q.charge_switch && !chg_rec));
         status_q.dsg1 <= prot_en.dsg1 && (dsg1_trip || (status_q.dsg1 && !dsg_rec));
         status_q.dsg2 <= prot_en.dsg2 && (dsg2_trip || (status_q.dsg2 && !dsg_rec));
         status_q.dsg3 <= prot_en.dsg3 && (dsg3_trip || (status_q.dsg3 && !dsg_rec));
      end
   end

   // ************************************************************
   // Discharge latch
   // ************************************************************

   latch_e latch_st_q;
   logic [7:0] dec_t_q;
   logic [7:0] lat_t_q;
   logic lat_cur_rec;
   logic lat_time_rec;
   logic lat_release;
   logic lat_trip;
   logic [CNT_W-1:0] trip_sum;
   assign trip_sum = CNT_W'(dsg1_trip) + CNT_W'(dsg2_trip) + CNT_W'(dsg3_trip); // Units from this cycle's trips
   assign lat_cur_rec = latch_cur_cond && slow_tick && (lat_rt_q + 8'h1 >= latch_recovery_time);
   assign lat_time_rec = slow_tick && (lat_t_q + 8'h1 >= latch_reset_time);
   assign lat_release = (latch_st_q == LATCH_TRIPPED)
                        && (load_removed || lat_cur_rec || lat_time_rec || latch_recover_cmd);
   assign lat_trip = prot_en.latch && (latch_st_q == LATCH_IDLE) && (latch_count_q > latch_limit);

   // Latch counter: up on each fault, down per quiet delay, cleared on release
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         latch_count_q <= '0;
         dec_t_q <= 8'h0;
      end else if (!prot_en.latch || lat_release) begin
         // A trip landing in the release cycle still counts
         latch_count_q <= prot_en.latch ? trip_sum : '0;
         dec_t_q <= 8'h0;
      end else if (|dsg_trip) begin
         latch_count_q <= latch_count_q + trip_sum;
         dec_t_q <= 8'h0;
      end else if (!dsg_any && latch_count_q != '0 && latch_st_q == LATCH_IDLE && slow_tick) begin
         if (dec_t_q + 8'h1 >= counter_dec_delay) begin
            latch_count_q <= latch_count_q - CNT_W'(1);
            dec_t_q <= 8'h0;
         end else begin
            dec_t_q <= dec_t_q + 8'h1;
         end
      end
   end

   // Latch state and its recovery timers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         latch_st_q <= LATCH_IDLE;
         lat_t_q <= 8'h0;
         lat_rt_q <= 8'h0;
      end else begin
         case (latch_st_q)
            LATCH_IDLE: begin
               if (lat_trip) begin
                  latch_st_q <= LATCH_TRIPPED;
               end
               lat_t_q <= 8'h0;
               lat_rt_q <= 8'h0;
            end
            LATCH_TRIPPED: begin
               if (!prot_en.latch || lat_release) begin
                  latch_st_q <= LATCH_IDLE;
                  lat_t_q <= 8'h0;
                  lat_rt_q <= 8'h0;
               end else begin
                  lat_t_q <= slow_tick ? lat_t_q + 8'h1 : lat_t_q;
                  lat_rt_q <= !latch_cur_cond ? 8'h0 : (slow_tick ? lat_rt_q + 8'h1 : lat_rt_q);
               end
            end
            default: latch_st_q <= LATCH_IDLE;
         endcase
      end
   end

   // Latch alert and status flags
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         alert_q.latch <= 1'b0;
         status_q.latch <= 1'b0;
      end else begin
         alert_q.latch <= prot_en.latch && (latch_count_q != '0) && !lat_trip
                          && latch_st_q == LATCH_IDLE;
         status_q.latch <= prot_en.latch && (lat_trip || (latch_st_q == LATCH_TRIPPED && !lat_release));
      end
   end

   // ************************************************************
   // Switch-off alarms
   // ************************************************************

   logic dsg_hold;
   assign dsg_hold = (status_q.dsg1 && dsg_auto_en[0]) || (status_q.dsg2 && dsg_auto_en[1])
                     || (status_q.dsg3 && dsg_auto_en[2]);

   // Alarms follow configured faults; trips win over recovery
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         charge_off_alarm_q <= 1'b0;
         discharge_off_alarm_q <= 1'b0;
      end else begin
         charge_off_alarm_q <= chg_auto_en && chg_on && (chg_trip || (status_q.charge_switch && !chg_rec));
         // Level recovery must not drop the alarm while the latch still holds it
         discharge_off_alarm_q <= |(dsg_trip & dsg_auto_en) || (lat_trip && latch_auto_en)
                                  || (dsg_hold && !dsg_rec)
                                  || (prot_en.latch && status_q.latch && latch_auto_en && !lat_release);
      end
   end

endmodule

// ===== verif/ocp_front_model.sv
// Far-side model: sense comparators, coulomb counter, charge switch driver.
// Assumes the bench sets wanted values; they reach the block one edge later.
`timescale 1ns/1ps
module ocp_front_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [7:0] chg_mv_set,
   input wire logic [7:0] dsg_mv_set,
   input wire logic signed [15:0] cur_set,
   input wire logic charge_off_alarm_q,
   output logic [7:0] charge_sense_mv,
   output logic [7:0] discharge_sense_mv,
   output logic signed [15:0] coulomb_counter_current,
   output logic charge_switch_on
);
   // Front end settles one edge late; the switch follows its alarm
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         charge_sense_mv <= 8'h00;
         discharge_sense_mv <= 8'h00;
         coulomb_counter_current <= 16'sh0000;
         charge_switch_on <= 1'b0;
      end else begin
         charge_sense_mv <= chg_mv_set;
         discharge_sense_mv <= dsg_mv_set;
         coulomb_counter_current <= cur_set;
         charge_switch_on <= !charge_off_alarm_q;
      end
   end
endmodule

// ===== verif/overcurrent_protection_fsm_properties.sv
// Checker of the overcurrent protection block, bound to its ports.
// Assumes one clock domain, mclk, with resetn low active.
`timescale 1ns/1ps
module ocp_checker
   import ocp_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire prot_en_s prot_en,
   input wire logic [7:0] charge_sense_mv,
   input wire logic [7:0] discharge_sense_mv,
   input wire logic [5:0] charge_sense_threshold,
   input wire logic [6:0] discharge_sense_threshold_1,
   input wire logic [6:0] charge_trip_delay,
   input wire logic chg_auto_en,
   input wire logic [2:0] dsg_auto_en,
   input wire logic [CNT_W-1:0] latch_limit,
   input wire prot_flags_s alert_q,
   input wire prot_flags_s status_q,
   input wire logic charge_off_alarm_q,
   input wire logic discharge_off_alarm_q,
   input wire logic [CNT_W-1:0] latch_count_q
);
   // ********
   // Properties
   // ********
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_chg_alert_match: assert property (prot_en.charge_switch && charge_trip_delay != 7'h00 && !status_q.charge_switch |=>
      alert_q.charge_switch == ($past(charge_sense_mv) > 8'h04 + {$past(charge_sense_threshold), 1'b0}) || status_q.charge_switch)
      else $error("charge alert wrong");
   a_dsg_alert_match: assert property (prot_en.dsg1 && !status_q.dsg1 |=>
      alert_q.dsg1 == ($past(discharge_sense_mv) > 9'h004 + {$past(discharge_sense_threshold_1), 1'b0}) ||
      status_q.dsg1) else $error("discharge alert wrong");
   a_chg_off_hold: assert property (!prot_en.charge_switch |=> !alert_q.charge_switch && !status_q.charge_switch)
      else $error("charge flags while disabled");
   a_chg_dly_zero: assert property (charge_trip_delay == 7'h00 |=> !alert_q.charge_switch && !status_q.charge_switch)
      else $error("charge flags with zero delay");
   a_chg_trip_alarm: assert property ($rose(status_q.charge_switch) |-> !alert_q.charge_switch &&
      charge_off_alarm_q == $past(chg_auto_en)) else $error("charge trip actions wrong");
   a_dsg_trip_alarm: assert property (($rose(status_q.dsg1) && $past(dsg_auto_en[0])) ||
      ($rose(status_q.dsg2) && $past(dsg_auto_en[1])) |-> discharge_off_alarm_q) else $error("no discharge alarm");
   a_latch_step: assert property ($rose(status_q.dsg1) && !$rose(status_q.dsg2) && !$rose(status_q.dsg3) &&
      $past(prot_en.latch) && !$past(status_q.latch) |-> latch_count_q == $past(latch_count_q) + 1'b1)
      else $error("latch count step wrong");
   a_latch_trip: assert property (prot_en.latch && latch_count_q > latch_limit |-> ##[0:2] status_q.latch)
      else $error("latch did not trip");
   a_latch_alert: assert property (prot_en.latch && latch_count_q != 0 && !status_q.latch |->
      ##[0:1] (alert_q.latch || status_q.latch)) else $error("latch alert missing");
endmodule
bind overcurrent_protection_fsm ocp_checker #(.CNT_W(CNT_W)) u_chk (.*);

// ===== verif/tb_overcurrent_protection_fsm.sv
// Self-checking bench of the overcurrent protection block.
// Assumes short tick parameters: 10 cycles per fast tick, 50 per second.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_overcurrent_protection_fsm
   import ocp_pkg::*;
;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   prot_en_s prot_en;
   prot_flags_s alert_q, status_q;
   logic [7:0] chg_mv_set, dsg_mv_set, charge_sense_mv, discharge_sense_mv, latch_count_q, latch_limit;
   logic signed [15:0] cur_set, coulomb_counter_current, dsg3_threshold, chg_recovery_threshold;
   logic signed [15:0] dsg_recovery_threshold, latch_recovery_threshold;
   logic [5:0] charge_sense_threshold;
   logic [6:0] discharge_sense_threshold_1, discharge_sense_threshold_2, charge_trip_delay;
   logic [6:0] discharge_trip_delay_1, discharge_trip_delay_2;
   logic [7:0] discharge_trip_delay_3, recovery_time, latch_recovery_time, latch_reset_time, counter_dec_delay;
   logic [15:0] pack_voltage, stack_voltage, pack_tos_delta;
   logic [2:0] dsg_auto_en;
   logic chg_auto_en, latch_auto_en, auto_recovery_en, latch_current_recovery_en, series_config;
   logic charge_switch_on, load_removed, latch_recover_cmd, charge_off_alarm_q, discharge_off_alarm_q;
   int errors = 0;
   int check_count = 0;
   int exp_cnt = 0;
   overcurrent_protection_fsm #(.FAST_UNIT(10), .SLOW_UNIT(50)) uut (.*);
   ocp_front_model front (.*);
   // 50 MHz clock
   initial forever #10 mclk = ~mclk;
   // ********
   // Helpers
   // ********
   task automatic wrap_up;
      $display("Checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wait_st(input int idx, input logic val, input int lim);
      int n;
      n = 0;
      while (status_q[idx] !== val && n < lim) begin
         cyc(1);
         n++;
      end
      `CHK(status_q[idx], val)
      if (n >= lim) wrap_up();
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_chg_quiet;
      @(posedge mclk);
      chg_mv_set <= 8'h18;
      cyc(5);
      `CHK(alert_q.charge_switch, 1'b0)
      @(posedge mclk);
      chg_mv_set <= 8'h7C;
      charge_trip_delay <= 7'h00;
      cyc(60);
      `CHK({alert_q.charge_switch, status_q.charge_switch, charge_off_alarm_q}, 3'b000)
      @(posedge mclk);
      charge_trip_delay <= 7'h01;
      prot_en.charge_switch <= 1'b0;
      cyc(60);
      `CHK({alert_q.charge_switch, status_q.charge_switch, charge_off_alarm_q}, 3'b000)
      @(posedge mclk);
      chg_mv_set <= 8'h00;
      prot_en.charge_switch <= 1'b1;
   endtask
   task automatic t_chg(input bit by_pack);
      @(posedge mclk);
      chg_mv_set <= 8'h19;
      cyc(3);
      `CHK(alert_q.charge_switch, 1'b1)
      cyc(15);
      `CHK(status_q.charge_switch, 1'b0)
      wait_st(4, 1'b1, 20);
      `CHK({alert_q.charge_switch, charge_off_alarm_q, discharge_off_alarm_q}, 3'b010)
      @(posedge mclk);
      chg_mv_set <= 8'h00;
      if (by_pack) stack_voltage <= 16'h1100;
      else cur_set <= -16'sh0020;
      wait_st(4, 1'b0, 150);
      `CHK(charge_off_alarm_q, 1'b0)
      @(posedge mclk);
      stack_voltage <= 16'h1000;
      cur_set <= 16'sh0000;
   endtask
   task automatic t_dsg(input int lvl, input logic latched);
      @(posedge mclk);
      prot_en.dsg1 <= (lvl == 1);
      prot_en.dsg2 <= (lvl == 2);
      prot_en.dsg3 <= (lvl == 3);
      dsg_mv_set <= 8'h32;
      if (lvl == 3) cur_set <= -16'sh00C8;
      wait_st(4 - lvl, 1'b1, 50);
      `CHK({status_q[3:1], discharge_off_alarm_q}, {3'b100 >> (lvl - 1), 1'b1})
      exp_cnt++;
      cyc(3);
      `CHK({latch_count_q, status_q.latch}, {exp_cnt[7:0], latched})
      if (!latched) `CHK(alert_q.latch, 1'b1)
      @(posedge mclk);
      dsg_mv_set <= 8'h00;
      cur_set <= 16'sh0014;
      wait_st(4 - lvl, 1'b0, 150);
      `CHK(discharge_off_alarm_q, latched)
      @(posedge mclk);
      cur_set <= 16'sh0000;
      prot_en <= 5'h1F;
   endtask
   task automatic t_latch(input int path);
      while (exp_cnt <= 4) t_dsg(1, exp_cnt == 4);
      @(posedge mclk);
      case (path)
         0: latch_recover_cmd <= 1'b1;
         1: load_removed <= 1'b1;
         2: begin
            series_config <= 1'b0;
            cur_set <= 16'sh0040;
         end
         default: latch_reset_time <= 8'h02;
      endcase
      if (path == 2) begin
         cyc(160);
         `CHK(status_q.latch, 1'b1)
         @(posedge mclk);
         series_config <= 1'b1;
      end
      wait_st(0, 1'b0, 220);
      `CHK({latch_count_q, discharge_off_alarm_q}, 9'h000)
      exp_cnt = 0;
      @(posedge mclk);
      latch_recover_cmd <= 1'b0;
      load_removed <= 1'b0;
      cur_set <= 16'sh0000;
      latch_reset_time <= 8'hFF;
   endtask
   task automatic t_dec;
      int n;
      @(posedge mclk);
      counter_dec_delay <= 8'h01;
      t_dsg(1, 1'b0);
      n = 0;
      while (latch_count_q !== 8'h00 && n < 200) begin
         cyc(1);
         n++;
      end
      cyc(1);
      `CHK({latch_count_q, alert_q.latch}, 9'h000)
      if (n >= 200) wrap_up();
   endtask
   // Main sequence
   initial begin
      prot_en = 5'h1F;
      chg_mv_set = 8'h00;
      dsg_mv_set = 8'h00;
      cur_set = 16'sh0000;
      dsg3_threshold = -16'sh0064;
      chg_recovery_threshold = -16'sh0010;
      dsg_recovery_threshold = 16'sh0010;
      latch_recovery_threshold = 16'sh0030;
      charge_sense_threshold = 6'h0A;
      discharge_sense_threshold_1 = 7'h0A;
      discharge_sense_threshold_2 = 7'h05;
      charge_trip_delay = 7'h01;
      discharge_trip_delay_1 = 7'h01;
      discharge_trip_delay_2 = 7'h02;
      discharge_trip_delay_3 = 8'h00;
      recovery_time = 8'h01;
      latch_recovery_time = 8'h01;
      latch_reset_time = 8'hFF;
      counter_dec_delay = 8'hFF;
      latch_limit = 8'h0A;
      pack_voltage = 16'h1000;
      stack_voltage = 16'h1000;
      pack_tos_delta = 16'h0080;
      dsg_auto_en = 3'b111;
      {chg_auto_en, latch_auto_en, auto_recovery_en, latch_current_recovery_en, series_config} = 5'h1F;
      {load_removed, latch_recover_cmd} = 2'b00;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      cyc(2);
      `CHK({alert_q, status_q, charge_off_alarm_q, discharge_off_alarm_q, latch_count_q}, 20'h00000)
      t_chg_quiet();
      t_chg(1'b0);
      t_chg(1'b1);
      for (int l = 1; l <= 3; l++) t_dsg(l, 1'b0);
      @(posedge mclk);
      latch_limit <= 8'h04;
      for (int p = 0; p < 4; p++) t_latch(p);
      t_dec();
      wrap_up();
   end
endmodule
